// [design/programmable_disk_ecc_unit.sv]
// Purpose: APB-controlled programmable ECC unit for the disk data path
// Assumes: Disk gates, bit strobe and pins synchronous to pclk
// Notes: Zero-wait APB slave; read data captured in the setup cycle
//
// Functional notes
// RULE_01: Control bit 7 picks 32 or 48 bits
// RULE_02: Control bit 6: 0 presets ones, 1 clears
// RULE_03: Bit 4 ORs sector/index, else codec reset
// RULE_04: Software: hard sectored 1, soft sectored 0
// RULE_05: Control bit 3 holds register in initial state
// RULE_06: Control bit 2 removes all feedback
// RULE_07: Writing bit 1 gives one shift, self-clears
// RULE_08: Manual shift loads bit 0 from control bit 0
// RULE_09: Software: clock running, gates off, no feedback
// RULE_10: Low syndrome bits 1-7 map by mode
// RULE_11: Low syndrome bit 0 ORs lower syndrome bits
// RULE_12: High syndrome register returns top eight bits
// RULE_13: First register holds taps 1 to 8
// RULE_14: Set tap adds top-xor-data into bit
// RULE_15: Second register holds taps 9 to 16
// RULE_16: Shared register: taps 1-8 or 17-24
// RULE_17: Remaining registers supply upper taps by mode
// RULE_18: 32-bit feedback uses bit 31
// RULE_19: Shared offset: read syndrome, write taps
`timescale 1ns/1ps
`default_nettype none

module programmable_disk_ecc_unit #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Disk data path
  input wire logic read_gate,
  input wire logic write_gate,
  input wire logic disk_bit_strobe,
  input wire logic serial_data,
  input wire logic ecc_init_req,
  // Sector and index pins
  input wire logic sector_or_codec_reset_pin,
  input wire logic index_pin,
  output logic branch_condition,
  output logic codec_counter_reset
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  generate
    if (ADDR_W < 9) begin : g_addr_chk
      $error("ADDR_W too small for the register indices");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [ecc_unit_pkg::POLY_REGS-1:0][7:0] poly;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic branch;
    logic codec_rst;
  } unit_state_t;

  unit_state_t state_r;
  unit_state_t state_nxt;

  logic [ecc_unit_pkg::IDX_W-1:0] idx;
  logic setup;
  logic access;
  logic wr_access;
  logic mode32;
  logic init_zero;
  logic clear_hold;
  logic feedback_off;
  logic manual_shift;
  logic gates_on;
  logic data_shift;
  logic lfsr_init;
  logic lfsr_shift;
  logic lfsr_serial_in;
  logic [ecc_unit_pkg::TAP_W-1:0] taps48;
  logic [ecc_unit_pkg::TAP_W-1:0] taps32;
  logic [ecc_unit_pkg::TAP_W-1:0] taps;
  logic [ecc_unit_pkg::ECC_W-1:0] ecc;
  logic [7:0] syn_lo;
  logic [7:0] syn_hi;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic idx_mapped(input logic [ecc_unit_pkg::IDX_W-1:0] i);
    idx_mapped = (i >= ecc_unit_pkg::IDX_CTRL) && (i <= ecc_unit_pkg::IDX_POLY5);
  endfunction : idx_mapped

  function automatic logic [2:0] poly_slot(input logic [ecc_unit_pkg::IDX_W-1:0] i);
    logic [ecc_unit_pkg::IDX_W-1:0] d;
    d = i - ecc_unit_pkg::IDX_SYN_LO_POLY0;
    poly_slot = d[2:0];
  endfunction : poly_slot

  assign idx = paddr[ecc_unit_pkg::IDX_LSB +: ecc_unit_pkg::IDX_W];
  assign setup = psel && !penable;
  assign access = psel && penable && state_r.pready;
  assign wr_access = access && pwrite;

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  assign mode32 = state_r.ctrl[ecc_unit_pkg::CTRL_MODE32_BIT]; // RULE_01
  assign init_zero = state_r.ctrl[ecc_unit_pkg::CTRL_INIT_ZERO_BIT]; // RULE_02
  assign clear_hold = state_r.ctrl[ecc_unit_pkg::CTRL_CLEAR_BIT];
  assign feedback_off = state_r.ctrl[ecc_unit_pkg::CTRL_NO_FEEDBACK_BIT];
  assign manual_shift = state_r.ctrl[ecc_unit_pkg::CTRL_SHIFT_BIT];
  assign gates_on = read_gate || write_gate;
  assign data_shift = gates_on && disk_bit_strobe;

  // Clear bit held keeps the register pinned to its initial value
  assign lfsr_init = clear_hold || ecc_init_req; // RULE_05
  // Disk traffic wins; software keeps gates off while shifting by hand
  assign lfsr_shift = data_shift || manual_shift; // RULE_07 RULE_09
  assign lfsr_serial_in = data_shift ? serial_data
                                     : state_r.ctrl[ecc_unit_pkg::CTRL_SERIAL_IN_BIT]; // RULE_08

  // ----------------------------------------------------------------
  // Tap assembly: taps[k] enables feedback into bit k+1
  // ----------------------------------------------------------------
  assign taps48 = {state_r.poly[5][6:0], state_r.poly[4], state_r.poly[3],
                   state_r.poly[2], state_r.poly[1], state_r.poly[0]}; // RULE_13 RULE_15 RULE_16 RULE_17
  assign taps32 = {ecc_unit_pkg::TAPS32_PAD, state_r.poly[5][6:0], state_r.poly[4],
                   state_r.poly[3], state_r.poly[2]}; // RULE_16 RULE_17
  assign taps = mode32 ? taps32 : taps48; // RULE_01

  ecc_shift_reg u_shift_reg (
    .pclk(pclk),
    .presetn(presetn),
    .init_load(lfsr_init),
    .init_zero(init_zero),
    .shift_en(lfsr_shift),
    .serial_in(lfsr_serial_in),
    .mode32(mode32),
    .feedback_off(feedback_off),
    .taps(taps),
    .ecc(ecc)
  );

  // ----------------------------------------------------------------
  // Syndrome readback
  // ----------------------------------------------------------------
  assign syn_lo = mode32 ? {ecc[23:17], |ecc[16:0]}
                         : {ecc[39:33], |ecc[32:0]}; // RULE_10 RULE_11
  assign syn_hi = mode32 ? ecc[31:24] : ecc[47:40]; // RULE_12

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.pready = setup;
    state_nxt.branch = state_r.ctrl[ecc_unit_pkg::CTRL_SECTOR_BRANCH_BIT]
                       ? (sector_or_codec_reset_pin || index_pin) : index_pin; // RULE_03
    state_nxt.codec_rst = !state_r.ctrl[ecc_unit_pkg::CTRL_SECTOR_BRANCH_BIT]
                          && sector_or_codec_reset_pin; // RULE_03
    // Shift request lasts one cycle, then drops by itself
    if (manual_shift) begin
      state_nxt.ctrl[ecc_unit_pkg::CTRL_SHIFT_BIT] = 1'b0; // RULE_07
    end
    // Error flag stands only beside pready, like the response it qualifies
    state_nxt.pslverr = 1'b0;
    // Read data frozen in setup so the access phase sees a stable word
    if (setup) begin
      state_nxt.pslverr = !idx_mapped(idx);
      state_nxt.prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (idx)
          ecc_unit_pkg::IDX_SYN_LO_POLY0: state_nxt.prdata = {24'h00_0000, syn_lo}; // RULE_19
          ecc_unit_pkg::IDX_SYN_HI_POLY1: state_nxt.prdata = {24'h00_0000, syn_hi}; // RULE_19
          default: state_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end
    // Writes land last so a new shift request beats the self-clear
    if (wr_access && idx_mapped(idx)) begin
      if (idx == ecc_unit_pkg::IDX_CTRL) begin
        state_nxt.ctrl = pwdata[7:0] & ecc_unit_pkg::CTRL_WMASK;
      end else if (idx == ecc_unit_pkg::IDX_POLY5) begin
        state_nxt.poly[poly_slot(idx)] = pwdata[7:0] & ecc_unit_pkg::POLY_TOP_MASK; // RULE_17
      end else begin
        state_nxt.poly[poly_slot(idx)] = pwdata[7:0]; // RULE_19
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r.ctrl <= ecc_unit_pkg::CTRL_RST;
      state_r.poly <= {ecc_unit_pkg::POLY_REGS{ecc_unit_pkg::POLY_RST}};
      state_r.prdata <= 32'h0000_0000;
      state_r.pready <= 1'b0;
      state_r.pslverr <= 1'b0;
      state_r.branch <= 1'b0;
      state_r.codec_rst <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign prdata = state_r.prdata;
  assign pready = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign branch_condition = state_r.branch;
  assign codec_counter_reset = state_r.codec_rst;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_shift_req;
  assign wr_shift_req = wr_access && (idx == ecc_unit_pkg::IDX_CTRL) && pwdata[1];

  shift_request_a: assert property (wr_shift_req |=> manual_shift) // RULE_07
    else $error("Shift request did not raise a pulse");

  shift_single_a: assert property (manual_shift && !wr_shift_req |=> !manual_shift) // RULE_07
    else $error("Shift pulse lasted more than one cycle");

  manual_load_a: assert property ( // RULE_08
    manual_shift && !data_shift && !lfsr_init && feedback_off
    |=> ecc[0] == $past(state_r.ctrl[0]) && ecc[47:1] == $past(ecc[46:0]))
    else $error("Manual shift did not load serial bit");

  clear_zero_a: assert property (clear_hold && init_zero |=> ecc == 48'h0000_0000_0000) // RULE_05
    else $error("Clear did not hold zeros");

  clear_preset_a: assert property ( // RULE_02
    clear_hold && !init_zero |=> ecc == 48'hffff_ffff_ffff)
    else $error("Clear did not hold ones");

  init_req_a: assert property ( // RULE_02
    ecc_init_req |=> ecc == ($past(init_zero) ? 48'h0000_0000_0000 : 48'hffff_ffff_ffff))
    else $error("Init request loaded wrong value");

  mode_write_a: assert property ( // RULE_01
    wr_access && idx == ecc_unit_pkg::IDX_CTRL |=> mode32 == $past(pwdata[7]))
    else $error("Mode bit write did not land");

  syn_low48_a: assert property ( // RULE_10
    setup && !pwrite && idx == ecc_unit_pkg::IDX_SYN_LO_POLY0 && !mode32
    |=> prdata[7:0] == {$past(ecc[39:33]), |$past(ecc[32:0])} && pready)
    else $error("48-bit low syndrome read wrong");

  syn_low32_a: assert property ( // RULE_11
    setup && !pwrite && idx == ecc_unit_pkg::IDX_SYN_LO_POLY0 && mode32
    |=> prdata[7:0] == {$past(ecc[23:17]), |$past(ecc[16:0])})
    else $error("32-bit low syndrome read wrong");

  syn_high_a: assert property ( // RULE_12
    setup && !pwrite && idx == ecc_unit_pkg::IDX_SYN_HI_POLY1
    |=> prdata[7:0] == ($past(mode32) ? $past(ecc[31:24]) : $past(ecc[47:40])))
    else $error("High syndrome read wrong");

  branch_mux_a: assert property ( // RULE_03
    ##1 branch_condition == ($past(state_r.ctrl[4])
    ? ($past(sector_or_codec_reset_pin) || $past(index_pin)) : $past(index_pin)))
    else $error("Sector branch multiplexing wrong");

  codec_reset_a: assert property ( // RULE_03
    ##1 codec_counter_reset == (!$past(state_r.ctrl[4]) && $past(sector_or_codec_reset_pin)))
    else $error("Codec reset gating wrong");

  // Tap wiring held against the raw slot registers, per mode
  first_taps_a: assert property ( // RULE_13
    !mode32 |-> taps[7:0] == state_r.poly[0] && taps[15:8] == state_r.poly[1])
    else $error("48-bit low tap wiring wrong");

  shared_taps_a: assert property ( // RULE_16
    mode32 ? (taps[7:0] == state_r.poly[2] && taps[46:31] == 16'h0000)
           : (taps[23:16] == state_r.poly[2]))
    else $error("Shared tap register wiring wrong");

  poly_top_a: assert property ( // RULE_17
    wr_access && idx == ecc_unit_pkg::IDX_POLY5
    |=> state_r.poly[5] == ($past(pwdata[7:0]) & 8'h7f))
    else $error("Top polynomial register write wrong");

  shared_write_a: assert property ( // RULE_19
    wr_access && idx == ecc_unit_pkg::IDX_SYN_LO_POLY0
    |=> state_r.poly[0] == $past(pwdata[7:0])
        && ($stable(ecc) || $past(lfsr_shift || lfsr_init)))
    else $error("Shared offset write touched syndrome");

  cover_manual_c: cover property (wr_shift_req ##1 manual_shift ##1 !manual_shift);
  cover_syn_read_c: cover property (setup && !pwrite && idx == ecc_unit_pkg::IDX_SYN_LO_POLY0);
  cover_clear_c: cover property (clear_hold [*3]);
  cover_slverr_c: cover property (access && pslverr);

endmodule : programmable_disk_ecc_unit
`default_nettype wire

// [design/ecc_unit_pkg.sv]
// Purpose: Shared constants for the programmable disk ECC unit
// Assumes: Register index times four gives the APB byte address
// Notes: Named bit positions, reset values and widths are defined here

package ecc_unit_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [6:0] IDX_CTRL = 7'h71;
  localparam logic [6:0] IDX_SYN_LO_POLY0 = 7'h72;
  localparam logic [6:0] IDX_SYN_HI_POLY1 = 7'h73;
  localparam logic [6:0] IDX_POLY2 = 7'h74;
  localparam logic [6:0] IDX_POLY3 = 7'h75;
  localparam logic [6:0] IDX_POLY4 = 7'h76;
  localparam logic [6:0] IDX_POLY5 = 7'h77;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 7;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_MODE32_BIT = 7;
  localparam int CTRL_INIT_ZERO_BIT = 6;
  localparam int CTRL_SECTOR_BRANCH_BIT = 4;
  localparam int CTRL_CLEAR_BIT = 3;
  localparam int CTRL_NO_FEEDBACK_BIT = 2;
  localparam int CTRL_SHIFT_BIT = 1;
  localparam int CTRL_SERIAL_IN_BIT = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hdf;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // ----------------------------------------------------------------
  // Polynomial and shift register layout
  // ----------------------------------------------------------------
  localparam int REG_W = 8;
  localparam int POLY_REGS = 6;
  localparam logic [7:0] POLY_RST = 8'h00;
  localparam logic [7:0] POLY_TOP_MASK = 8'h7f;
  localparam int ECC_W = 48;
  localparam int TAP_W = 47;
  localparam int TOP48_BIT = 47;
  localparam int TOP32_BIT = 31;
  localparam logic [47:0] ECC_PRESET = 48'hffff_ffff_ffff;
  localparam logic [47:0] ECC_CLEARED = 48'h0000_0000_0000;
  localparam logic [15:0] TAPS32_PAD = 16'h0000;

endpackage : ecc_unit_pkg

// [design/ecc_shift_reg.sv]
// Purpose: 48-bit programmable feedback shift register for disk ECC
// Assumes: One shift per cycle with shift_en; init_load has priority
// Notes: In 32-bit mode the upper bits keep shifting but are unused
`timescale 1ns/1ps
`default_nettype none

module ecc_shift_reg (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic init_load,
  input wire logic init_zero,
  input wire logic shift_en,
  input wire logic serial_in,
  input wire logic mode32,
  input wire logic feedback_off,
  input wire logic [ecc_unit_pkg::TAP_W-1:0] taps,
  // Contents
  output logic [ecc_unit_pkg::ECC_W-1:0] ecc
);

  typedef struct packed {
    logic [ecc_unit_pkg::ECC_W-1:0] ecc;
  } lfsr_state_t;

  lfsr_state_t state_r;
  lfsr_state_t state_nxt;
  logic fb;
  logic [ecc_unit_pkg::ECC_W-1:0] shifted;

  // ----------------------------------------------------------------
  // Feedback network
  // ----------------------------------------------------------------
  assign fb = (mode32 ? state_r.ecc[ecc_unit_pkg::TOP32_BIT]
                      : state_r.ecc[ecc_unit_pkg::TOP48_BIT]) ^ serial_in; // RULE_14 RULE_18
  assign shifted[0] = feedback_off ? serial_in : fb; // RULE_06

  genvar n;
  generate
    for (n = 1; n < ecc_unit_pkg::ECC_W; n++) begin : g_tap
      assign shifted[n] = state_r.ecc[n-1] ^ (~feedback_off & taps[n-1] & fb); // RULE_14 RULE_06
    end
  endgenerate

  always_comb begin
    state_nxt = state_r;
    if (init_load) begin
      state_nxt.ecc = init_zero ? ecc_unit_pkg::ECC_CLEARED : ecc_unit_pkg::ECC_PRESET; // RULE_02
    end else if (shift_en) begin
      state_nxt.ecc = shifted;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r.ecc <= ecc_unit_pkg::ECC_PRESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign ecc = state_r.ecc;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  fb_tap48_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
    shift_en && !init_load && !feedback_off && !mode32 |=>
      ecc[1] == $past(ecc[0] ^ (taps[0] & (ecc[47] ^ serial_in))))
    else $error("48-bit feedback into bit 1 wrong");

  fb_tap32_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
    shift_en && !init_load && !feedback_off && mode32 |=>
      ecc[1] == $past(ecc[0] ^ (taps[0] & (ecc[31] ^ serial_in))))
    else $error("32-bit feedback into bit 1 wrong");

  plain_shift_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    shift_en && !init_load && feedback_off |=>
      ecc == {$past(ecc[46:0]), $past(serial_in)})
    else $error("Shift without feedback wrong");

endmodule : ecc_shift_reg
`default_nettype wire

// [dv/disk_seq_model.sv]
// Purpose: Disk sequencer side model: gates, bit strobes, init request, pins
// Assumes: Every output changes just after a rising pclk edge
// Notes: Data line toggles between strobes so a stale bit is never held
`timescale 1ns/1ps
`default_nettype none

module disk_seq_model (
  // Clock
  input wire logic pclk,
  // Disk data path
  output logic read_gate,
  output logic write_gate,
  output logic disk_bit_strobe,
  output logic serial_data,
  output logic ecc_init_req,
  // Sector and index pins
  output logic sector_or_codec_reset_pin,
  output logic index_pin
);
  initial begin
    {read_gate, write_gate, disk_bit_strobe, serial_data} = 4'h0;
    {ecc_init_req, sector_or_codec_reset_pin, index_pin} = 3'h0;
  end

  // ----------------------------------------------------------------
  // Frames, MSB first; gap 0 keeps strobes back to back
  // ----------------------------------------------------------------
  task automatic send(input logic [47:0] bits, input int n, input logic wg, input int gap);
    int i;
    int k;
    @(posedge pclk);
    read_gate <= !wg;
    write_gate <= wg;
    for (i = n - 1; i >= 0; i--) begin
      @(posedge pclk);
      disk_bit_strobe <= 1'b1;
      serial_data <= bits[i];
      for (k = 0; k < gap; k++) begin
        @(posedge pclk);
        disk_bit_strobe <= 1'b0;
        serial_data <= ~serial_data;
      end
    end
    @(posedge pclk);
    {read_gate, write_gate, disk_bit_strobe} <= 3'h0;
  endtask : send

  task automatic init_pulse();
    @(posedge pclk);
    ecc_init_req <= 1'b1;
    @(posedge pclk);
    ecc_init_req <= 1'b0;
  endtask : init_pulse

  task automatic pins(input logic s, input logic i);
    @(posedge pclk);
    sector_or_codec_reset_pin <= s;
    index_pin <= i;
  endtask : pins
endmodule : disk_seq_model
`default_nettype wire

// [dv/testbench.sv]
// Purpose: Self-checking bench for the programmable disk ECC unit
// Assumes: APB master waits on pready; expected ECC kept bit by bit here
// Notes: Manual shifts always run with feedback off and both gates low
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic read_gate;
  logic write_gate;
  logic disk_bit_strobe;
  logic serial_data;
  logic ecc_init_req;
  logic sector_or_codec_reset_pin;
  logic index_pin;
  logic branch_condition;
  logic codec_counter_reset;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic er;
  logic [47:0] e_exp;
  logic [7:0] ctrl;
  logic [7:0] poly [6];

  programmable_disk_ecc_unit i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .read_gate, .write_gate, .disk_bit_strobe, .serial_data, .ecc_init_req,
    .sector_or_codec_reset_pin, .index_pin, .branch_condition, .codec_counter_reset
  );
  disk_seq_model i_seq (
    .pclk, .read_gate, .write_gate, .disk_bit_strobe, .serial_data, .ecc_init_req,
    .sector_or_codec_reset_pin, .index_pin
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Reference shift register
  // ----------------------------------------------------------------
  function automatic logic tap_on(int n, logic m32);
    if (m32) return (n < 32) ? poly[2 + (n - 1) / 8][(n - 1) % 8] : 1'b0;
    return poly[(n - 1) / 8][(n - 1) % 8];
  endfunction : tap_on

  function automatic logic [47:0] nxt(logic [47:0] e, logic d, logic fbo);
    logic [47:0] r;
    logic fb;
    fb = (ctrl[7] ? e[31] : e[47]) ^ d;
    r = {e[46:0], fbo ? d : fb};
    for (int n = 1; n < 48; n++) if (!fbo && tap_on(n, ctrl[7])) r[n] = r[n] ^ fb;
    return r;
  endfunction : nxt

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [6:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {3'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [6:0] idx, input logic [31:0] exp, input logic experr);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, experr});
  endtask : rdchk

  task automatic set_ctrl(input logic [7:0] d);
    ctrl = d;
    apb(1'b1, ecc_unit_pkg::IDX_CTRL, d);
  endtask : set_ctrl

  task automatic set_poly(input int s, input logic [7:0] d);
    poly[s] = d;
    apb(1'b1, ecc_unit_pkg::IDX_SYN_LO_POLY0 + 7'(s), d);
  endtask : set_poly

  task automatic mshift(input logic b);
    set_ctrl((ctrl & 8'hfc) | 8'h02 | {7'h0, b});
    e_exp = nxt(e_exp, b, 1'b1);
  endtask : mshift

  task automatic frame(input logic [47:0] bits, input int n, input logic wg, input int gap);
    i_seq.send(bits, n, wg, gap);
    for (int i = n - 1; i >= 0; i--) e_exp = nxt(e_exp, bits[i], ctrl[2]);
  endtask : frame

  task automatic syn_chk();
    logic [7:0] lo;
    logic [7:0] hi;
    lo = ctrl[7] ? {e_exp[23:17], |e_exp[16:0]} : {e_exp[39:33], |e_exp[32:0]};
    hi = ctrl[7] ? e_exp[31:24] : e_exp[47:40];
    rdchk(ecc_unit_pkg::IDX_SYN_LO_POLY0, {24'h0, lo}, 1'b0);
    rdchk(ecc_unit_pkg::IDX_SYN_HI_POLY1, {24'h0, hi}, 1'b0);
  endtask : syn_chk

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    e_exp = ecc_unit_pkg::ECC_PRESET;
    ctrl = 8'h00;
    poly = '{default: 8'h00};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    syn_chk();
    rdchk(ecc_unit_pkg::IDX_CTRL, 32'h0, 1'b0);
    rdchk(7'h70, 32'h0, 1'b1);
    apb(1'b1, 7'h78, 8'h55);
    chk({31'h0, er}, 32'h0000_0001);
    rdchk(7'h78, 32'h0, 1'b1);
    set_poly(0, 8'h5a);
    syn_chk();
    set_ctrl(8'h4c);
    e_exp = ecc_unit_pkg::ECC_CLEARED;
    syn_chk();
    set_ctrl(8'h44);
    for (int i = 47; i >= 0; i--) mshift(1'(48'hc3a5_9617_e08d >> i));
    syn_chk();
    set_ctrl(8'hc4);
    syn_chk();
    // Preset through the clear bit, then full 48-bit feedback
    set_ctrl(8'h08);
    set_ctrl(8'h00);
    e_exp = ecc_unit_pkg::ECC_PRESET;
    set_poly(0, 8'h81);
    set_poly(1, 8'h42);
    set_poly(2, 8'h24);
    set_poly(3, 8'h18);
    set_poly(4, 8'h3c);
    set_poly(5, 8'hff);
    frame(48'h9b3c_5e71_d2a4, 48, 1'b0, 0);
    syn_chk();
    set_ctrl(8'h88);
    set_ctrl(8'h80);
    e_exp = ecc_unit_pkg::ECC_PRESET;
    frame(48'h0f1e_2d3c_4b5a, 40, 1'b1, 2);
    syn_chk();
    set_ctrl(8'hc0);
    i_seq.init_pulse();
    e_exp = ecc_unit_pkg::ECC_CLEARED;
    syn_chk();
    for (int c = 0; c < 2; c++) begin
      set_ctrl((c != 0) ? 8'h10 : 8'h00);
      for (int p = 0; p < 4; p++) begin
        i_seq.pins(p[1], p[0]);
        repeat (3) @(posedge pclk);
        chk({31'h0, branch_condition}, (c != 0) ? 32'(p != 0) : 32'(p[0]));
        chk({31'h0, codec_counter_reset}, 32'(c == 0 && p[1]));
      end
    end
    finish_test();
  end
endmodule : testbench
`default_nettype wire
